// File: test/modem_model.sv
// Purpose: Behavioural modem that answers the channel's handshake and serial pins.
// Assumes: Shares the channel clock; all lines idle high out of reset.
// Notes: flip_i makes every line answer wrongly, to prove loopback ignores them.
`timescale 1ns/100ps
module modem_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic flip_i,
  input wire logic rts_n_i,
  input wire logic dtr_n_i,
  input wire logic tx_line_i,
  output logic cts_n_o,
  output logic dsr_n_o,
  output logic ri_n_o,
  output logic dcd_n_o,
  output logic rx_line_o
);
  logic [11:0] line_reg;
  logic [2:0] tap;

  // A four-deep delay line lets the modem answer one cycle or four cycles late.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      line_reg <= 12'hFFF;
    end else begin
      line_reg <= {line_reg[8:0], rts_n_i, dtr_n_i, tx_line_i};
    end
  end

  // Request loops to clear, ready to set, serial out back to serial in.
  assign tap = slow_i ? line_reg[11:9] : line_reg[2:0];
  assign cts_n_o = tap[2] ^ flip_i;
  assign dsr_n_o = tap[1] ^ flip_i;
  assign rx_line_o = tap[0] ^ flip_i;
  assign ri_n_o = ~flip_i;
  assign dcd_n_o = ~flip_i;
endmodule

// File: test/tb.sv
// Purpose: Self-checking bench for the modem control block.
// Assumes: Block and modem model share one 250 MHz clock.
// Notes: Random register values are mixed with hand-picked corners.
`timescale 1ns/100ps
module tb;
  logic mclk_i, rst_i, wr, rd, tick16, tx_bit, tx_idle, rx_valid;
  logic baud_clk, dma_rdy, slow, flip, ser_in, cts_n, dsr_n, ri_n, dcd_n, tx_start;
  logic ser_out, rts_n, dtr_n, aux2, rx_bit, rx_store, tx_hold, tick_ref, change;
  logic [1:0] alt_sel;
  logic [3:0] addr;
  logic [3:0] tcnt = 4'h0;
  logic [7:0] wdata, rdata, rx_char, v, got;
  int failures, checks_done, seed, i, n;

  modem_ctrl dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .baud_ref_tick_o(tick_ref), .tick16_i(tick16), .tx_bit_i(tx_bit),
    .tx_bit_start_i(tx_start), .tx_idle_i(tx_idle), .rx_bit_o(rx_bit),
    .rx_char_valid_i(rx_valid), .rx_char_i(rx_char), .rx_store_o(rx_store),
    .tx_hold_o(tx_hold), .baud_clock_i(baud_clk), .rx_dma_ready_i(dma_rdy),
    .alt_pin_sel_i(alt_sel), .serial_in_pin_i(ser_in), .cts_n_pin_i(cts_n),
    .dsr_n_pin_i(dsr_n), .ri_n_pin_i(ri_n), .dcd_n_pin_i(dcd_n),
    .serial_out_pin_o(ser_out), .rts_n_o(rts_n), .dtr_n_o(dtr_n), .aux2_pin_o(aux2),
    .modem_change_o(change));

  modem_model modem_u (.mclk_i(mclk_i), .rst_i(rst_i), .slow_i(slow), .flip_i(flip),
    .rts_n_i(rts_n), .dtr_n_i(dtr_n), .tx_line_i(ser_out), .cts_n_o(cts_n), .dsr_n_o(dsr_n),
    .ri_n_o(ri_n), .dcd_n_o(dcd_n), .rx_line_o(ser_in));

  // Clock at 4 ns period.
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  // Sixteen-times sample enable, one pulse in sixteen cycles.
  always @(posedge mclk_i) begin
    tcnt <= tcnt + 4'h1;
    tick16 <= &tcnt;
  end

  // Pin order is aux two, request, ready, serial out; loopback parks all high.
  function automatic logic [3:0] pins_exp(input logic [7:0] c);
    if (c[4]) return 4'hF;
    return {~c[3], ~c[1], ~c[0], 1'b1};
  endfunction

  // Status nibble dcd, ri, dsr, cts; outside loopback the modem echoes request and ready.
  function automatic logic [3:0] stat_exp(input logic [7:0] c);
    if (c[4]) return {c[3], c[2], c[0], c[1]};
    return {2'b00, c[0], c[1]};
  endfunction

  // Shared pin with aux two set: baud clock, dma ready, or aux two driven low.
  function automatic logic aux_exp(input logic [7:0] c);
    if (c[1:0] == 2'b01) return c[2];
    if (c[1:0] == 2'b11) return c[3];
    return 1'b0;
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just then.
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask

  task automatic rxc(input logic [7:0] c, input logic st, input logic hd);
    @(posedge mclk_i);
    rx_char <= c;
    rx_valid <= 1'b1;
    @(posedge mclk_i);
    rx_valid <= 1'b0;
    #1;
    chk("rx_store", {7'h00, st}, {7'h00, rx_store});
    chk("tx_hold", {7'h00, hd}, {7'h00, tx_hold});
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // The tests need under a thousand cycles; this cuts a hang well beyond that.
  initial begin
    #100000;
    failures++;
    results();
  end

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    {wr, rd, rx_valid, baud_clk, dma_rdy, slow, flip} = 7'h00;
    {tx_bit, tx_idle, rst_i} = 3'h7;
    tx_start = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    rx_char = 8'h00;
    alt_sel = 2'b00;
    seed = 13;
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    cyc(2);
    chk("pins", 8'h0F, {4'h0, aux2, rts_n, dtr_n, ser_out});
    chk("tick", 8'h01, {7'h00, tick_ref});
    rd_reg(mcr_pkg::MCR_OFS, got);
    chk("control", mcr_pkg::MCR_RST, got);
    wr_reg(4'hF, 8'hFF);
    rd_reg(4'hF, got);
    chk("unmapped", 8'h00, got);
    $display("test reset finished");
    for (i = 0; i < 16; i++) begin
      v = $random(seed) & 8'hBF;
      flip <= v[4];
      slow <= i[0];
      wr_reg(mcr_pkg::MCR_OFS, v);
      cyc(14);
      chk("pins", {4'h0, pins_exp(v)}, {4'h0, aux2, rts_n, dtr_n, ser_out});
      rd_reg(mcr_pkg::MCR_OFS, got);
      chk("control", v, got);
      rd_reg(mcr_pkg::MSR_OFS, got);
      chk("status", {4'h0, stat_exp(v)}, {4'h0, got[7:4]});
    end
    flip <= 1'b0;
    $display("test random control finished");
    for (i = 0; i < 2; i++) begin
      wr_reg(mcr_pkg::MCR_OFS, {i[0], 7'h00});
      cyc(2);
      n = 0;
      repeat (40) begin
        n += tick_ref;
        cyc(1);
      end
      chk("ticks", i[0] ? 8'h0A : 8'h28, n[7:0]);
    end
    wr_reg(mcr_pkg::MCR_OFS, 8'h40);
    // The decoder stretches the last high level over sixteen ticks, so wait them out.
    cyc(280);
    chk("ir_idle", 8'h00, {7'h00, ser_out});
    chk("ir_rx", 8'h01, {7'h00, rx_bit});
    // A zero bit goes out as a short high pulse and comes back as a stretched zero.
    @(posedge mclk_i);
    tx_start <= 1'b1;
    tx_bit <= 1'b0;
    tx_idle <= 1'b0;
    @(posedge mclk_i);
    tx_start <= 1'b0;
    cyc(1);
    chk("ir_pulse", 8'h01, {7'h00, ser_out});
    cyc(12);
    chk("ir_rx_pulse", 8'h00, {7'h00, rx_bit});
    cyc(60);
    chk("ir_pulse_end", 8'h00, {7'h00, ser_out});
    tx_idle <= 1'b1;
    tx_bit <= 1'b1;
    $display("test divider and infrared finished");
    wr_reg(mcr_pkg::MCR_OFS, 8'h10);
    for (i = 0; i < 2; i++) begin
      flip <= i[0];
      tx_bit <= i[0];
      cyc(10);
      chk("rx_bit", {7'h00, i[0]}, {7'h00, rx_bit});
      chk("ser_out", 8'h01, {7'h00, ser_out});
    end
    flip <= 1'b0;
    tx_bit <= 1'b1;
    cyc(10);
    rd_reg(mcr_pkg::MSR_OFS, got);
    rd_reg(mcr_pkg::MSR_OFS, got);
    chk("change", 8'h00, {7'h00, change});
    wr_reg(mcr_pkg::MCR_OFS, 8'h12);
    cyc(4);
    chk("change", 8'h01, {7'h00, change});
    rd_reg(mcr_pkg::MSR_OFS, got);
    chk("status", 8'h11, got & 8'hF1);
    $display("test loopback finished");
    wr_reg(mcr_pkg::FLOW_CTRL_OFS, 8'h01);
    wr_reg(mcr_pkg::MCR_OFS, 8'h00);
    rxc(mcr_pkg::XOFF_RST, 1'b0, 1'b1);
    rxc(8'h41, 1'b1, 1'b1);
    rxc(mcr_pkg::XON_RST, 1'b0, 1'b0);
    wr_reg(mcr_pkg::MCR_OFS, 8'h20);
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      if (v == mcr_pkg::XON_RST || v == mcr_pkg::XOFF_RST) begin
        v = 8'h00;
      end
      rxc(mcr_pkg::XOFF_RST, 1'b0, 1'b1);
      rxc(v, 1'b1, 1'b0);
    end
    rxc(mcr_pkg::XOFF_RST, 1'b0, 1'b1);
    rxc(mcr_pkg::XON_RST, 1'b0, 1'b0);
    $display("test flow control finished");
    wr_reg(mcr_pkg::MCR_OFS, 8'h08);
    for (i = 0; i < 12; i++) begin
      v = $random(seed);
      alt_sel <= v[1:0];
      baud_clk <= v[2];
      dma_rdy <= v[3];
      cyc(3);
      chk("aux2_pin", {7'h00, aux_exp(v)}, {7'h00, aux2});
    end
    $display("test shared pin finished");
    results();
  end
endmodule

// File: verilog/mcr_pkg.sv
// Purpose: Shared constants and types for the modem control block.
// Assumes: One 8-bit register port with 4-bit byte addresses.
// Notes: Flow control registers sit above the status register.
package mcr_pkg;
  // ************************************************
  // Register map
  // ************************************************
  localparam logic [3:0] MCR_OFS = 4'h4;
  localparam logic [3:0] MSR_OFS = 4'h6;
  localparam logic [3:0] FLOW_CTRL_OFS = 4'h8;
  localparam logic [3:0] XON_OFS = 4'h9;
  localparam logic [3:0] XOFF_OFS = 4'hA;
  localparam logic [3:0] FLOW_STAT_OFS = 4'hB;

  // Control register fields.
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_AUX1 = 2;
  localparam int MCR_AUX2 = 3;
  localparam int MCR_LOOP = 4;
  localparam int MCR_XANY = 5;
  localparam int MCR_IR = 6;
  localparam int MCR_DIV4 = 7;
  localparam int FLOW_EN = 0;

  // Reset values.
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] XON_RST = 8'h11;
  localparam logic [7:0] XOFF_RST = 8'h13;

  // ************************************************
  // Timing
  // ************************************************
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [4:0] IR_PULSE_TICKS = 5'h03;
  localparam logic [4:0] BIT_TICKS = 5'h10;

  // Pin function selected for the shared auxiliary pin.
  typedef enum logic [1:0] {
    PIN_AUX2 = 2'b00,
    PIN_BAUD = 2'b01,
    PIN_RXRDY = 2'b11
  } alt_pin_sel_t;

  // Transmit flow state.
  typedef enum logic {
    FLOW_RUN = 1'b0,
    FLOW_HELD = 1'b1
  } flow_state_t;

  // Modem handshake status, active high.
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_stat_t;
endpackage

// File: verilog/modem_ctrl.sv
// Purpose: Per-channel modem control register and its channel effects.
// Assumes: Transmitter, receiver, baud generator and FIFOs live outside.
// Notes: Contract
// Contract
// - Bit 7 selects crystal divide by four.
// - Bit 6 selects infrared encode and decode.
// - Infrared idle transmit output held low.
// - Xon-any resumes on any received character except Xoff.
// - Xon or Xoff characters never stored; code stores them while flow control is disabled.
// - Loopback drives serial output to mark.
// - Loopback routes transmit data to receiver.
// - Loopback routes handshake outputs to inputs.
// - Loopback forces handshake output pins high.
// - Receive and transmit interrupts keep working.
// - Loopback status changes come from control bits.
// - Bit 3 drives auxiliary output two, inverted.
// - Shared pin muxed by alternate function select.
// - Auxiliary output one drives no pin.
// - Loopback auxiliary one sets ring status.
// - Bit 1 drives active-low request pin.
// - Bit 0 drives active-low ready pin.
// - Pre-divider works down to a stopped clock.
`timescale 1ns/100ps
module modem_ctrl (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic baud_ref_tick_o,
  input wire logic tick16_i,
  input wire logic tx_bit_i,
  input wire logic tx_bit_start_i,
  input wire logic tx_idle_i,
  output logic rx_bit_o,
  input wire logic rx_char_valid_i,
  input wire logic [7:0] rx_char_i,
  output logic rx_store_o,
  output logic tx_hold_o,
  input wire logic baud_clock_i,
  input wire logic rx_dma_ready_i,
  input wire logic [1:0] alt_pin_sel_i,
  input wire logic serial_in_pin_i,
  input wire logic cts_n_pin_i,
  input wire logic dsr_n_pin_i,
  input wire logic ri_n_pin_i,
  input wire logic dcd_n_pin_i,
  output logic serial_out_pin_o,
  output logic rts_n_o,
  output logic dtr_n_o,
  output logic aux2_pin_o,
  output logic modem_change_o
);
  // ************************************************
  // Registers and declarations
  // ************************************************
  logic [7:0] modem_control_reg;
  logic flow_en_reg;
  logic [7:0] xon_reg;
  logic [7:0] xoff_reg;
  logic [1:0] prescale_reg;
  logic [4:0] ir_tx_cnt_reg;
  logic [4:0] ir_rx_cnt_reg;
  logic [3:0] delta_reg;
  mcr_pkg::modem_stat_t status_reg;
  mcr_pkg::modem_stat_t status_next;
  mcr_pkg::flow_state_t flow_reg;
  logic [4:0] pins_sync;
  logic loop_on;
  logic ir_on;
  logic rx_pin_high;
  logic is_flow_char;
  logic msr_read;

  assign loop_on = modem_control_reg[mcr_pkg::MCR_LOOP];
  assign ir_on = modem_control_reg[mcr_pkg::MCR_IR];
  assign rx_pin_high = pins_sync[4];
  assign msr_read = reg_rd_i && (reg_addr_i == mcr_pkg::MSR_OFS);
  assign is_flow_char = (rx_char_i == xon_reg) || (rx_char_i == xoff_reg);

  // ************************************************
  // Pin synchronisers
  // ************************************************
  // Serial input idles high; handshake inputs idle high (inactive).
  pin_sync3 #(
    .WIDTH(5),
    .RST_VAL(5'h1F)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({serial_in_pin_i, dcd_n_pin_i, ri_n_pin_i, dsr_n_pin_i, cts_n_pin_i}),
    .q_o(pins_sync)
  );

  // ************************************************
  // Register port
  // ************************************************
  // Software writes; all fields reset to zero or the default flow characters.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      modem_control_reg <= mcr_pkg::MCR_RST;
      flow_en_reg <= 1'b0;
      xon_reg <= mcr_pkg::XON_RST;
      xoff_reg <= mcr_pkg::XOFF_RST;
    end else if (ce_i && reg_wr_i) begin
      case (reg_addr_i)
        mcr_pkg::MCR_OFS: begin
          modem_control_reg <= reg_wdata_i;
        end
        mcr_pkg::FLOW_CTRL_OFS: begin
          flow_en_reg <= reg_wdata_i[mcr_pkg::FLOW_EN];
        end
        mcr_pkg::XON_OFS: begin
          xon_reg <= reg_wdata_i;
        end
        mcr_pkg::XOFF_OFS: begin
          xoff_reg <= reg_wdata_i;
        end
        default: begin
        end
      endcase
    end
  end

  // Read data stands in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i) begin
      reg_rdata_o <= 8'h00;
      if (reg_rd_i) begin
        case (reg_addr_i)
          mcr_pkg::MCR_OFS: begin
            reg_rdata_o <= modem_control_reg;
          end
          mcr_pkg::MSR_OFS: begin
            reg_rdata_o <= {status_reg, delta_reg};
          end
          mcr_pkg::FLOW_CTRL_OFS: begin
            reg_rdata_o <= {7'h00, flow_en_reg};
          end
          mcr_pkg::XON_OFS: begin
            reg_rdata_o <= xon_reg;
          end
          mcr_pkg::XOFF_OFS: begin
            reg_rdata_o <= xoff_reg;
          end
          mcr_pkg::FLOW_STAT_OFS: begin
            reg_rdata_o <= {7'h00, flow_reg == mcr_pkg::FLOW_HELD};
          end
          default: begin
            reg_rdata_o <= 8'h00;
          end
        endcase
      end
    end
  end

  // ************************************************
  // Clock pre-divider
  // ************************************************
  // Counts enables rather than edges, so any crystal rate down to a
  // stopped clock is accepted.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prescale_reg <= 2'h0;
    end else if (ce_i) begin
      prescale_reg <= (prescale_reg == mcr_pkg::PRESCALE_LAST) ? 2'h0 : prescale_reg + 2'h1;
    end
  end

  // Divide by one passes every enable; divide by four every fourth.
  assign baud_ref_tick_o = ce_i &&
    (!modem_control_reg[mcr_pkg::MCR_DIV4] || (prescale_reg == 2'h0));

  // ************************************************
  // Infrared encoder and decoder
  // ************************************************
  // A zero bit is sent as a short high pulse of three 16x ticks.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ir_tx_cnt_reg <= 5'h00;
    end else if (ce_i) begin
      if (tx_bit_start_i && !tx_bit_i) begin
        ir_tx_cnt_reg <= mcr_pkg::IR_PULSE_TICKS;
      end else if (tick16_i && (ir_tx_cnt_reg != 5'h00)) begin
        ir_tx_cnt_reg <= ir_tx_cnt_reg - 5'h01;
      end
    end
  end

  // A received pulse is stretched over one bit time as a zero.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ir_rx_cnt_reg <= 5'h00;
    end else if (ce_i) begin
      if (rx_pin_high) begin
        ir_rx_cnt_reg <= mcr_pkg::BIT_TICKS;
      end else if (tick16_i && (ir_rx_cnt_reg != 5'h00)) begin
        ir_rx_cnt_reg <= ir_rx_cnt_reg - 5'h01;
      end
    end
  end

  // ************************************************
  // Serial paths
  // ************************************************
  // Loopback marks the line; infrared idles low, so idle forces zero.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      serial_out_pin_o <= 1'b1;
    end else if (ce_i) begin
      if (loop_on) begin
        serial_out_pin_o <= 1'b1;
      end else if (ir_on) begin
        serial_out_pin_o <= !tx_idle_i && (ir_tx_cnt_reg != 5'h00);
      end else begin
        serial_out_pin_o <= tx_bit_i;
      end
    end
  end

  // Loopback feeds the receiver from the transmitter and drops the pin.
  // Receiver interrupts therefore run unchanged outside this block.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_bit_o <= 1'b1;
    end else if (ce_i) begin
      if (loop_on) begin
        rx_bit_o <= tx_bit_i;
      end else if (ir_on) begin
        rx_bit_o <= (ir_rx_cnt_reg == 5'h00);
      end else begin
        rx_bit_o <= rx_pin_high;
      end
    end
  end

  // ************************************************
  // Handshake and auxiliary pins
  // ************************************************
  // Control bits are inverted onto active-low pins; loopback parks them high.
  // Auxiliary one has no pin at all outside loopback.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
      aux2_pin_o <= 1'b1;
    end else if (ce_i) begin
      if (loop_on) begin
        rts_n_o <= 1'b1;
        dtr_n_o <= 1'b1;
        aux2_pin_o <= 1'b1;
      end else begin
        rts_n_o <= !modem_control_reg[mcr_pkg::MCR_RTS];
        dtr_n_o <= !modem_control_reg[mcr_pkg::MCR_DTR];
        case (mcr_pkg::alt_pin_sel_t'(alt_pin_sel_i))
          mcr_pkg::PIN_BAUD: begin
            aux2_pin_o <= baud_clock_i;
          end
          mcr_pkg::PIN_RXRDY: begin
            aux2_pin_o <= rx_dma_ready_i;
          end
          default: begin
            aux2_pin_o <= !modem_control_reg[mcr_pkg::MCR_AUX2];
          end
        endcase
      end
    end
  end

  // ************************************************
  // Modem status
  // ************************************************
  // Loopback takes status from control bits in the customary pairing.
  always_comb begin
    if (loop_on) begin
      status_next.cts = modem_control_reg[mcr_pkg::MCR_RTS];
      status_next.dsr = modem_control_reg[mcr_pkg::MCR_DTR];
      status_next.ri = modem_control_reg[mcr_pkg::MCR_AUX1];
      status_next.dcd = modem_control_reg[mcr_pkg::MCR_AUX2];
    end else begin
      status_next.cts = !pins_sync[0];
      status_next.dsr = !pins_sync[1];
      status_next.ri = !pins_sync[2];
      status_next.dcd = !pins_sync[3];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      status_reg <= '0;
    end else if (ce_i) begin
      status_reg <= status_next;
    end
  end

  // Change flags are sticky and cleared by reading status; a change in the
  // read cycle survives, since losing it would hide an edge.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      delta_reg <= 4'h0;
    end else if (ce_i) begin
      delta_reg <= (msr_read ? 4'h0 : delta_reg) | {
        status_reg.dcd ^ status_next.dcd,
        status_reg.ri && !status_next.ri,
        status_reg.dsr ^ status_next.dsr,
        status_reg.cts ^ status_next.cts};
    end
  end

  assign modem_change_o = |delta_reg;

  // ************************************************
  // Software flow control
  // ************************************************
  // Xoff holds the transmitter; Xon, or any other character with Xon-any, resumes.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      flow_reg <= mcr_pkg::FLOW_RUN;
    end else if (ce_i) begin
      if (!flow_en_reg) begin
        flow_reg <= mcr_pkg::FLOW_RUN;
      end else if (rx_char_valid_i) begin
        if (rx_char_i == xoff_reg) begin
          flow_reg <= mcr_pkg::FLOW_HELD;
        end else if (rx_char_i == xon_reg) begin
          flow_reg <= mcr_pkg::FLOW_RUN;
        end else if (modem_control_reg[mcr_pkg::MCR_XANY]) begin
          flow_reg <= mcr_pkg::FLOW_RUN;
        end
      end
    end
  end

  assign tx_hold_o = (flow_reg == mcr_pkg::FLOW_HELD);

  // With flow control enabled, flow characters are consumed here, never passed to the receive FIFO.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_store_o <= 1'b0;
    end else if (ce_i) begin
      rx_store_o <= rx_char_valid_i && !(flow_en_reg && is_flow_char);
    end else begin
      rx_store_o <= 1'b0;
    end
  end

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  AST_DIV1: assert property (ce_i && !modem_control_reg[7] |-> baud_ref_tick_o)
    else $error("Divide by one missed a tick.");
  AST_DIV4: assert property (baud_ref_tick_o && modem_control_reg[7] && !reg_wr_i
    |=> !baud_ref_tick_o)
    else $error("Divide by four ticked twice in a row.");
  AST_IR_IDLE: assert property (ce_i && ir_on && !loop_on && tx_idle_i
    |=> !serial_out_pin_o)
    else $error("Infrared idle output not low.");
  AST_LOOP_MARK: assert property (ce_i && loop_on |=> serial_out_pin_o)
    else $error("Loopback serial output not marking.");
  AST_LOOP_RX: assert property (ce_i && loop_on |=> rx_bit_o == $past(tx_bit_i))
    else $error("Loopback receive bit differs from transmit bit.");
  AST_LOOP_HS: assert property (ce_i && loop_on |=> status_reg.cts == $past(
    modem_control_reg[1]) && status_reg.dsr == $past(modem_control_reg[0]))
    else $error("Loopback handshake status not routed.");
  AST_LOOP_PINS: assert property (ce_i && loop_on |=> rts_n_o && dtr_n_o && aux2_pin_o)
    else $error("Loopback handshake pins not inactive.");
  AST_RI_LOOP: assert property (ce_i && loop_on
    |=> status_reg.ri == $past(modem_control_reg[2]))
    else $error("Ring status does not follow auxiliary one.");
  AST_RTS: assert property (ce_i && !loop_on |=> rts_n_o == !$past(modem_control_reg[1]))
    else $error("Request pin does not follow bit 1.");
  AST_DTR: assert property (ce_i && !loop_on |=> dtr_n_o == !$past(modem_control_reg[0]))
    else $error("Ready pin does not follow bit 0.");
  AST_XANY: assert property (ce_i && flow_en_reg && modem_control_reg[5] && rx_char_valid_i
    && !is_flow_char |=> !tx_hold_o)
    else $error("Xon-any did not resume transmit.");
  AST_NO_STORE: assert property (ce_i && flow_en_reg && rx_char_valid_i && is_flow_char
    |=> !rx_store_o)
    else $error("Flow character was stored.");

  COV_LOOP: cover property (ce_i && loop_on && tx_bit_i ##1 rx_bit_o);
  COV_IR_PULSE: cover property (ir_on && !loop_on && serial_out_pin_o);
  COV_XANY: cover property (tx_hold_o ##1 !tx_hold_o && modem_control_reg[5]);
  COV_MSR_READ: cover property (msr_read && |delta_reg);
endmodule

// File: verilog/pin_sync3.sv
// Purpose: Three-stage synchroniser for a group of pin inputs.
// Assumes: Inputs are asynchronous to mclk_i.
// Notes: Output moves only when stages two and three agree.
`timescale 1ns/100ps
module pin_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  // ************************************************
  // Per-bit synchroniser chain
  // ************************************************
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      // Stage one feeds stage two only, so metastability cannot leak.
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          s1_reg <= RST_VAL[gi];
          s2_reg <= RST_VAL[gi];
          s3_reg <= RST_VAL[gi];
          q_o[gi] <= RST_VAL[gi];
        end else if (ce_i) begin
          s1_reg <= d_i[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            q_o[gi] <= s3_reg; // A change counts once both stages agree.
          end
        end
      end
    end
  endgenerate
endmodule
